// ### rtl/efpc_top.sv
/*
  Fault sequencing and protection logic of a hot-swap fuse: shared fault
  lines, strap decode, power-good, peak capture, start-up limit banding,
  soft-start checks and three-level over-current debounce.
  Assumes analogue comparators arrive as asynchronous levels and that the
  register port is a simple synchronous strobe interface on clk.
*/
`timescale 1ns/1ns
`default_nettype none
module efpc_top #(
  parameter int unsigned RETRY_CYC = 100000,
  parameter int unsigned CL_CYC    = 500000,
  parameter int unsigned SS_CYC    = 5000000,
  parameter int unsigned DEB_SCALE = 1
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [3:0]  strap_code,
  input  wire logic        enable_pin,
  input  wire logic        host_disable,
  input  wire logic        shared_fault_in,
  output logic             shared_fault_oe_n,
  input  wire logic        slave_fault_in,
  output logic             slave_fault_oe_n,
  output logic             power_good_oe_n,
  output logic             gate_on,
  output logic             is_master,
  output logic [3:0]       address_offset,
  output logic             addressed,
  output logic             xfer_enable,
  output logic [7:0]       startup_limit,
  input  wire logic        vin_high,
  input  wire logic [1:0]  vout_band,
  input  wire logic        vout_near_vin,
  input  wire logic        vout_above_th,
  input  wire logic        vgs_ok,
  input  wire logic        current_limiting,
  input  wire logic        short_detect,
  input  wire logic        other_fault,
  input  wire logic        over_temp,
  input  wire logic        temp_in_slave_band,
  input  wire logic        temp_below_warn,
  input  wire logic        link_fail_evt,
  input  wire logic        link_continue,
  input  wire logic [2:0]  oc_above,
  input  wire logic [2:0]  oc_below_hyst,
  input  wire logic [15:0] current_monitor,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic [15:0]      reg_rdata
);
  // Release window must stay at least one cycle long after scaling
  if (RETRY_CYC < 1 || CL_CYC < 1 || SS_CYC < 1 || DEB_SCALE < 1 ||
      DEB_SCALE > efpc_pkg::OC_RELEASE_CYC) begin : g_bad_param
    $error("efpc_top: timer parameters out of range");
  end

  // Three-stage synchronisers for eleven asynchronous levels; oc_above, oc_below_hyst, vin_high, vout_band and other_fault are not synchronised
  localparam int NS = 11;
  // Fault lines idle high, all other levels idle low, so reset makes no false edge
  localparam logic [NS-1:0] SYNC_IDLE = 11'h600;
  logic [NS-1:0] async_in, s1, s2, s3, sync_q;
  assign async_in = {shared_fault_in, slave_fault_in, enable_pin, vout_near_vin, vout_above_th,
                     vgs_ok, current_limiting, short_detect, over_temp, temp_below_warn,
                     temp_in_slave_band};
  genvar gi;
  generate
    for (gi = 0; gi < NS; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (rst) begin
          s1[gi]     <= SYNC_IDLE[gi];
          s2[gi]     <= SYNC_IDLE[gi];
          s3[gi]     <= SYNC_IDLE[gi];
          sync_q[gi] <= SYNC_IDLE[gi];
        end else begin
          s1[gi] <= async_in[gi];
          s2[gi] <= s1[gi];
          s3[gi] <= s2[gi];
          if (s2[gi] == s3[gi])
            sync_q[gi] <= s3[gi];
        end
      end
    end
  endgenerate
  logic shared_low, slave_low, en_s, near_s, vout_s, vgs_s, cl_s, sc_s, ot_s, cool_s, band_s;
  assign {shared_low, slave_low} = ~sync_q[10:9];
  assign {en_s, near_s, vout_s, vgs_s, cl_s, sc_s, ot_s, cool_s, band_s} = sync_q[8:0];

  // strap decode, caught after reset release
  logic strap_done_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      strap_done_reg <= 1'b0;
      is_master      <= 1'b0;
      address_offset <= 4'h0;
      addressed      <= 1'b0;
      xfer_enable    <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      is_master      <= strap_code <= efpc_pkg::STRAP_MASTER_LAST;
      address_offset <= (strap_code <= efpc_pkg::STRAP_SLAVE_LAST) ? strap_code : 4'h0;
      addressed      <= strap_code <= efpc_pkg::STRAP_SLAVE_LAST;
      xfer_enable    <= (strap_code < efpc_pkg::STRAP_XFER_OFF_M) ||
                        (strap_code > efpc_pkg::STRAP_MASTER_LAST &&
                         strap_code < efpc_pkg::STRAP_XFER_OFF_S) ||
                        (strap_code == efpc_pkg::STRAP_GROUND);
    end
  end

  // Registers
  logic [15:0] alert_mask_reg, oc_config_reg, peak_reg;
  logic        link_fault_reg, latched_flag;
  logic [1:0]  link_fail_cnt;
  logic        retry_mode;
  assign retry_mode = oc_config_reg[efpc_pkg::CF_RETRY];
  always_ff @(posedge clk) begin
    if (rst) begin
      alert_mask_reg <= efpc_pkg::ALERT_MASK_RST;
      oc_config_reg  <= efpc_pkg::OC_CONFIG_RST;
    end else if (reg_wr) begin
      if (reg_addr == efpc_pkg::REG_ALERT_MASK)
        alert_mask_reg <= reg_wdata;
      if (reg_addr == efpc_pkg::REG_OC_CONFIG)
        oc_config_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      link_fail_cnt  <= 2'd0;
      link_fault_reg <= 1'b0;
    end else if (link_fail_evt && is_master && !link_continue && !link_fault_reg) begin
      if (link_fail_cnt == 2'(efpc_pkg::LINK_FAIL_LIMIT - 1))
        link_fault_reg <= 1'b1;
      else
        link_fail_cnt <= link_fail_cnt + 2'd1;
    end
  end

  logic [2:0] oc_trip;
  logic       oc_armed;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_oc
      logic [31:0] deb_cnt, rel_cnt, deb_lim;
      logic [1:0]  lvl, dsel;
      logic        ab, bh;
      assign lvl  = oc_config_reg[efpc_pkg::CF_LEVEL_LSB + 2*gi +: 2];
      assign dsel = oc_config_reg[efpc_pkg::CF_DELAY_LSB + 2*gi +: 2];
      assign ab   = oc_above[gi];
      assign bh   = oc_below_hyst[gi];
      always_comb begin
        case (dsel)
          2'd0:    deb_lim = efpc_pkg::DEB_US_0 * efpc_pkg::CLK_MHZ / DEB_SCALE;
          2'd1:    deb_lim = efpc_pkg::DEB_US_1 * efpc_pkg::CLK_MHZ / DEB_SCALE;
          2'd2:    deb_lim = efpc_pkg::DEB_US_2 * efpc_pkg::CLK_MHZ / DEB_SCALE;
          default: deb_lim = efpc_pkg::DEB_US_3 * efpc_pkg::CLK_MHZ / DEB_SCALE;
        endcase
      end
      always_ff @(posedge clk) begin
        if (rst || lvl == 2'b00 || !oc_armed) begin
          deb_cnt     <= 32'd0;
          rel_cnt     <= 32'd0;
          oc_trip[gi] <= 1'b0;
        end else if (deb_cnt != 32'd0 || ab) begin
          rel_cnt <= bh ? rel_cnt + 32'd1 : 32'd0;
          if (bh && rel_cnt >= efpc_pkg::OC_RELEASE_CYC / DEB_SCALE - 1)
            deb_cnt <= 32'd0;
          // Expired timer only trips while the level is still exceeded
          else if (deb_cnt >= deb_lim - 1) begin
            if (ab)
              oc_trip[gi] <= 1'b1;
          end else
            deb_cnt <= deb_cnt + 32'd1;
        end
      end
    end
  endgenerate

  // Main sequencer
  efpc_pkg::efpc_state_e state_reg;
  logic [31:0] seq_cnt, cl_cnt;
  logic        en_prev, own_fault, thermal_trip, relay_fault;
  logic [7:0]  relay_cnt;
  assign own_fault = sc_s || other_fault || (|oc_trip) ||
                     (ot_s && (is_master ? !band_s : band_s)) ||
                     (cl_s && cl_cnt >= CL_CYC - 1);
  // master relays slave fault after delay
  always_ff @(posedge clk) begin
    if (rst || !slave_low || !is_master) begin
      relay_cnt   <= 8'd0;
      relay_fault <= 1'b0;
    end else if (relay_cnt >= 8'(efpc_pkg::FAULT_RELAY_CYC - 1))
      relay_fault <= 1'b1;
    else
      relay_cnt <= relay_cnt + 8'd1;
  end
  always_ff @(posedge clk) begin
    if (rst || !cl_s || state_reg != efpc_pkg::EFPC_START)
      cl_cnt <= 32'd0;
    else
      cl_cnt <= cl_cnt + 32'd1;
  end
  logic fault_now;
  assign fault_now = (state_reg == efpc_pkg::EFPC_START || state_reg == efpc_pkg::EFPC_ON) &&
                     (own_fault || (is_master ? relay_fault : shared_low) ||
                      (state_reg == efpc_pkg::EFPC_START && seq_cnt >= SS_CYC - 1 &&
                       !(vout_s && vgs_s)));
  // remember a thermal shutdown until the next power-up attempt
  always_ff @(posedge clk) begin
    if (rst || state_reg == efpc_pkg::EFPC_OFF)
      thermal_trip <= 1'b0;
    else if (fault_now && ot_s)
      thermal_trip <= 1'b1;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg    <= efpc_pkg::EFPC_OFF;
      seq_cnt      <= 32'd0;
      en_prev      <= 1'b0;
      latched_flag <= 1'b0;
    end else begin
      en_prev <= en_s;
      case (state_reg)
        efpc_pkg::EFPC_OFF: begin
          seq_cnt <= 32'd0;
          if (en_s && !host_disable && !shared_low)
            state_reg <= efpc_pkg::EFPC_START;
        end
        efpc_pkg::EFPC_START, efpc_pkg::EFPC_ON: begin
          seq_cnt <= seq_cnt + 32'd1;
          if (fault_now) begin
            seq_cnt <= 32'd0;
            // retry or latch, slaves follow master
            if (retry_mode || !is_master)
              state_reg <= efpc_pkg::EFPC_WAIT;
            else begin
              state_reg    <= efpc_pkg::EFPC_LATCH;
              latched_flag <= 1'b1;
            end
          end else if (host_disable || !en_s)
            state_reg <= efpc_pkg::EFPC_OFF;
          else if (state_reg == efpc_pkg::EFPC_START && near_s && vgs_s)
            state_reg <= efpc_pkg::EFPC_ON;
        end
        efpc_pkg::EFPC_WAIT: begin
          if (seq_cnt < RETRY_CYC - 1)
            seq_cnt <= seq_cnt + 32'd1;
          // Master ignores the shared line here, it is the one holding it low
          else if ((!thermal_trip || cool_s) && (is_master || !shared_low) && !(|oc_trip))
            state_reg <= efpc_pkg::EFPC_OFF;
        end
        efpc_pkg::EFPC_LATCH: begin
          if (en_prev && !en_s) begin
            state_reg    <= efpc_pkg::EFPC_OFF;
            latched_flag <= 1'b0;
          end
        end
        default: state_reg <= efpc_pkg::EFPC_OFF;
      endcase
    end
  end
  assign oc_armed = state_reg == efpc_pkg::EFPC_ON;

  logic faulted;
  assign faulted = state_reg == efpc_pkg::EFPC_WAIT || state_reg == efpc_pkg::EFPC_LATCH;
  always_ff @(posedge clk) begin
    if (rst) begin
      shared_fault_oe_n <= 1'b1;
      slave_fault_oe_n  <= 1'b1;
    end else begin
      shared_fault_oe_n <= !(link_fault_reg || (is_master && (faulted || fault_now)));
      slave_fault_oe_n  <= !(link_fault_reg || (!is_master && (faulted || fault_now)));
    end
  end
  // gate off at once on short
  assign gate_on = (state_reg == efpc_pkg::EFPC_START || state_reg == efpc_pkg::EFPC_ON) &&
                   !sc_s;
  assign power_good_oe_n = state_reg == efpc_pkg::EFPC_ON;

  always_ff @(posedge clk) begin
    if (rst)
      startup_limit <= efpc_pkg::SL_LO_0;
    else case (vout_band)
      2'd0:    startup_limit <= vin_high ? efpc_pkg::SL_HI_0 : efpc_pkg::SL_LO_0;
      2'd1:    startup_limit <= vin_high ? efpc_pkg::SL_HI_1 : efpc_pkg::SL_LO_1;
      default: startup_limit <= vin_high ? efpc_pkg::SL_HI_2 : efpc_pkg::SL_LO_2;
    endcase
  end

  // peak capture, any non-zero over-current sample wins over read clear
  logic oc_entry, peak_read;
  assign oc_entry  = oc_armed && (|oc_above);
  assign peak_read = reg_rd && reg_addr == efpc_pkg::REG_PEAK_CAPTURE;
  always_ff @(posedge clk) begin
    if (rst)
      peak_reg <= efpc_pkg::PEAK_RST;
    else if (oc_entry && current_monitor > (peak_read ? 16'h0000 : peak_reg))
      peak_reg <= current_monitor;
    else if (peak_read)
      peak_reg <= efpc_pkg::PEAK_RST;
  end

  // Read data
  logic [7:0] status_w;
  always_comb begin
    status_w = 8'h00;
    status_w[efpc_pkg::ST_LINK_FAULT] = link_fault_reg && is_master;
    status_w[efpc_pkg::ST_PG_N]       = state_reg != efpc_pkg::EFPC_ON;
    status_w[efpc_pkg::ST_LATCHED]    = latched_flag;
  end
  always_ff @(posedge clk) begin
    if (rst)
      reg_rdata <= 16'h0000;
    else if (reg_rd) begin
      case (reg_addr)
        efpc_pkg::REG_ALERT_MASK:    reg_rdata <= alert_mask_reg;
        efpc_pkg::REG_VENDOR_STATUS: reg_rdata <= {8'h00, status_w};
        efpc_pkg::REG_PEAK_CAPTURE:  reg_rdata <= peak_reg;
        efpc_pkg::REG_OC_CONFIG:     reg_rdata <= oc_config_reg;
        default:                     reg_rdata <= 16'h0000;
      endcase
    end
  end

  a_relay_delay: assert property (@(posedge clk) disable iff (rst)
    is_master && slave_low [*8] |-> ##[0:60] relay_fault) else $error("relay late");
  a_pg_on_fault: assert property (@(posedge clk) disable iff (rst)
    faulted |-> !power_good_oe_n) else $error("pg high in fault");
  a_peak_clear: assert property (@(posedge clk) disable iff (rst)
    peak_read && !oc_entry |=> peak_reg == 16'h0000) else $error("peak not cleared");
  a_peak_mono: assert property (@(posedge clk) disable iff (rst)
    !peak_read |=> peak_reg >= $past(peak_reg)) else $error("peak fell");
  a_short_gate: assert property (@(posedge clk) disable iff (rst)
    sc_s |-> !gate_on) else $error("gate on in short");
  a_latch_hold: assert property (@(posedge clk) disable iff (rst)
    state_reg == efpc_pkg::EFPC_LATCH && en_s |=> state_reg == efpc_pkg::EFPC_LATCH)
    else $error("latch left");
  // master never pulls slave line on own fault
  a_master_line: assert property (@(posedge clk) disable iff (rst)
    is_master && !link_fault_reg |=> slave_fault_oe_n) else $error("master drove slave line");
  a_level_off: assert property (@(posedge clk) disable iff (rst)
    oc_config_reg[1:0] == 2'b00 |=> !oc_trip[0]) else $error("disabled level tripped");
  a_link_lines: assert property (@(posedge clk) disable iff (rst)
    link_fault_reg |=> !shared_fault_oe_n && !slave_fault_oe_n) else $error("link fault not driven");
  a_thermal_hold: assert property (@(posedge clk) disable iff (rst)
    state_reg == efpc_pkg::EFPC_WAIT && thermal_trip && !cool_s |=>
    state_reg == efpc_pkg::EFPC_WAIT) else $error("thermal retry too early");
endmodule
`default_nettype wire

// ### rtl/efpc_pkg.sv
/*
  Constants for the fuse protection controller: register offsets, field
  positions, timing figures and derived cycle counts.
  Assumes a 100 MHz core clock.
*/
package efpc_pkg;
  localparam int unsigned CLK_MHZ            = 100;
  localparam logic [7:0]  REG_ALERT_MASK     = 8'h1b;
  localparam logic [7:0]  REG_VENDOR_STATUS  = 8'h80;
  localparam logic [7:0]  REG_PEAK_CAPTURE   = 8'hc4;
  localparam logic [7:0]  REG_OC_CONFIG      = 8'hc9;
  localparam logic [15:0] ALERT_MASK_RST     = 16'h0000;
  localparam logic [15:0] OC_CONFIG_RST      = 16'h0000;
  localparam logic [15:0] PEAK_RST           = 16'h0000;
  // Status bit positions
  localparam int unsigned ST_LINK_FAULT      = 2;
  localparam int unsigned ST_PG_N            = 3;
  localparam int unsigned ST_LATCHED         = 4;
  // Config field positions: levels [1:0],[3:2],[5:4]; delays [7:6],[9:8],[11:10]
  localparam int unsigned CF_LEVEL_LSB       = 0;
  localparam int unsigned CF_DELAY_LSB       = 6;
  localparam int unsigned CF_RETRY           = 12;
  // Strap codes
  localparam logic [3:0]  STRAP_MASTER_LAST  = 4'h2;
  localparam logic [3:0]  STRAP_XFER_OFF_M   = 4'h2;
  localparam logic [3:0]  STRAP_XFER_OFF_S   = 4'h9;
  localparam logic [3:0]  STRAP_SLAVE_LAST   = 4'he;
  localparam logic [3:0]  STRAP_GROUND       = 4'hf;
  localparam int unsigned LINK_FAIL_LIMIT    = 3;
  // Times
  localparam int unsigned FAULT_RELAY_NS     = 500;
  localparam int unsigned FAULT_RELAY_CYC    = FAULT_RELAY_NS * CLK_MHZ / 1000;
  localparam int unsigned OC_RELEASE_US      = 100;
  localparam int unsigned OC_RELEASE_CYC     = OC_RELEASE_US * CLK_MHZ;
  localparam int unsigned DEB_US_0           = 250;
  localparam int unsigned DEB_US_1           = 1000;
  localparam int unsigned DEB_US_2           = 10000;
  localparam int unsigned DEB_US_3           = 50000;
  // Start-up limit codes (amps x2 for 7.5)
  localparam logic [7:0]  SL_LO_0 = 8'h0f;
  localparam logic [7:0]  SL_LO_1 = 8'h1e;
  localparam logic [7:0]  SL_LO_2 = 8'h3c;
  localparam logic [7:0]  SL_HI_0 = 8'h0a;
  localparam logic [7:0]  SL_HI_1 = 8'h14;
  localparam logic [7:0]  SL_HI_2 = 8'h28;
  typedef enum logic [2:0] {
    EFPC_OFF   = 3'b000,
    EFPC_START = 3'b001,
    EFPC_ON    = 3'b010,
    EFPC_WAIT  = 3'b011,
    EFPC_LATCH = 3'b100
  } efpc_state_e;
endpackage

// ### dv/efpc_peer_model.sv
/*
  Model of a paralleled fuse seen on the two open-drain fault lines.
  Assumes pull-ups on both lines and bench requests made on clk.
*/
`timescale 1ns/1ns
`default_nettype none
module efpc_peer_model (
  input  wire logic       clk,
  input  wire logic       pull_shared,
  input  wire logic       pull_slave,
  input  wire logic [3:0] lag,
  input  wire logic       dut_shared_oe_n,
  input  wire logic       dut_slave_oe_n,
  output logic            shared_line,
  output logic            slave_line
);
  logic [3:0] cnt_reg;
  logic       sh_reg;
  logic       sl_reg;

  initial begin
    cnt_reg = 4'h0;
    sh_reg = 1'b0;
    sl_reg = 1'b0;
  end

  always @(posedge clk) begin
    if (!(pull_shared || pull_slave)) begin
      cnt_reg <= 4'h0;
      sh_reg <= 1'b0;
      sl_reg <= 1'b0;
    end else if (cnt_reg < lag) begin
      cnt_reg <= cnt_reg + 4'h1;
    end else begin
      sh_reg <= pull_shared;
      sl_reg <= pull_slave;
    end
  end

  assign shared_line = dut_shared_oe_n & !sh_reg;
  assign slave_line  = dut_slave_oe_n & !sl_reg;
endmodule
`default_nettype wire

// ### dv/tb_efuse_fault_protection_control.sv
/*
  Self-checking bench for the fuse protection controller.
  Assumes efpc_top with shortened timers and the peer model on the fault lines.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_efuse_fault_protection_control;
  typedef struct {
    logic [15:0] exp;
    logic [15:0] msk;
    int          sel;
  } efpc_note_s;
  localparam logic [7:0] LIM [6] = '{efpc_pkg::SL_LO_0, efpc_pkg::SL_HI_0, efpc_pkg::SL_LO_1,
                                     efpc_pkg::SL_HI_1, efpc_pkg::SL_LO_2, efpc_pkg::SL_HI_2};
  logic        clk, rst, enable_pin, host_disable, vin_high, vout_near_vin, vout_above_th;
  logic        vgs_ok, current_limiting, short_detect, other_fault, over_temp;
  logic        temp_in_slave_band, temp_below_warn, link_fail_evt, link_continue;
  logic        reg_wr, reg_rd, pull_sh, pull_sl, shared_line, slave_line;
  logic        shared_fault_oe_n, slave_fault_oe_n, power_good_oe_n, gate_on;
  logic        is_master, addressed, xfer_enable;
  logic        rd_taken = 1'b0;
  logic [1:0]  vout_band;
  logic [2:0]  oc_above, oc_below_hyst;
  logic [3:0]  strap_code, address_offset, peer_lag;
  logic [7:0]  reg_addr, startup_limit;
  logic [15:0] current_monitor, reg_wdata, reg_rdata, pk;
  logic [31:0] seed = 32'h1bfa0a3f;
  int          errors = 0;
  int          checked = 0;
  int          k;
  efpc_note_s  pin_q[$];
  efpc_note_s  reg_q[$];

  efpc_top #(.RETRY_CYC(20), .CL_CYC(20), .SS_CYC(200), .DEB_SCALE(100)) DUT (
    .clk(clk), .rst(rst), .strap_code(strap_code), .enable_pin(enable_pin),
    .host_disable(host_disable), .shared_fault_in(shared_line),
    .shared_fault_oe_n(shared_fault_oe_n), .slave_fault_in(slave_line),
    .slave_fault_oe_n(slave_fault_oe_n), .power_good_oe_n(power_good_oe_n),
    .gate_on(gate_on), .is_master(is_master), .address_offset(address_offset),
    .addressed(addressed), .xfer_enable(xfer_enable), .startup_limit(startup_limit),
    .vin_high(vin_high), .vout_band(vout_band), .vout_near_vin(vout_near_vin),
    .vout_above_th(vout_above_th), .vgs_ok(vgs_ok), .current_limiting(current_limiting),
    .short_detect(short_detect), .other_fault(other_fault), .over_temp(over_temp),
    .temp_in_slave_band(temp_in_slave_band), .temp_below_warn(temp_below_warn),
    .link_fail_evt(link_fail_evt), .link_continue(link_continue), .oc_above(oc_above),
    .oc_below_hyst(oc_below_hyst), .current_monitor(current_monitor), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  efpc_peer_model PEER (.clk(clk), .pull_shared(pull_sh), .pull_slave(pull_sl),
    .lag(peer_lag), .dut_shared_oe_n(shared_fault_oe_n), .dut_slave_oe_n(slave_fault_oe_n),
    .shared_line(shared_line), .slave_line(slave_line));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [15:0] obs(input int s);
    case (s)
      0: return {15'h0, shared_fault_oe_n};
      1: return {15'h0, slave_fault_oe_n};
      2: return {15'h0, power_good_oe_n};
      3: return {15'h0, gate_on};
      4: return {15'h0, is_master};
      5: return {15'h0, addressed};
      6: return {15'h0, xfer_enable};
      7: return {12'h0, address_offset};
      default: return {8'h0, startup_limit};
    endcase
  endfunction

  task automatic stop_test();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic cmp_pin(input efpc_note_s n);
    checked++;
    if (obs(n.sel) !== n.exp) begin
      errors++;
      $display("ERROR %0t pin %0d is %h want %h", $time, n.sel, obs(n.sel), n.exp);
    end
  endtask

  task automatic cmp_reg(input efpc_note_s n);
    checked++;
    if ((reg_rdata & n.msk) !== (n.exp & n.msk)) begin
      errors++;
      $display("ERROR %0t read %h want %h", $time, reg_rdata, n.exp);
    end
  endtask

  task automatic note(input int s, input logic [15:0] e);
    pin_q.push_back('{e, 16'hffff, s});
  endtask

  // Value must not show before lo cycles and must show by hi cycles
  task automatic window(input int s, input logic v, input int lo, input int hi);
    int i;
    repeat (lo) @(negedge clk);
    if (lo > 0) note(s, {15'h0, !v});
    for (i = lo; i < hi && obs(s) !== {15'h0, v}; i++) @(negedge clk);
    note(s, {15'h0, v});
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
    reg_addr = a;
    reg_rd = 1'b1;
    reg_q.push_back('{e, m, 0});
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  task automatic go_on();
    {enable_pin, vout_near_vin, vout_above_th, vgs_ok} = 4'hf;
    window(2, 1'b1, 0, 40);
  endtask

  task automatic do_reset(input logic [3:0] s);
    rst = 1'b1;
    strap_code = s;
    {enable_pin, host_disable, vin_high, vout_near_vin, vout_above_th, vgs_ok, current_limiting,
     short_detect, other_fault, over_temp, temp_in_slave_band, link_fail_evt, reg_wr, reg_rd,
     pull_sh, pull_sl} = 16'h0;
    {link_continue, temp_below_warn} = 2'b11;
    {vout_band, oc_above, oc_below_hyst} = 8'h0;
    {current_monitor, reg_wdata, reg_addr} = 40'h0;
    peer_lag = 4'h3;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
  endtask

  always @(posedge clk) rd_taken <= reg_rd;

  always @(negedge clk) begin
    #1;
    if (rd_taken) cmp_reg(reg_q.pop_front());
    while (pin_q.size() > 0) cmp_pin(pin_q.pop_front());
  end

  // Tests need about 2000 cycles; this allows ten times that
  initial begin
    #200000;
    errors++;
    stop_test();
  end

  initial begin
    do_reset(4'h0);
    note(0, 16'h1);
    note(1, 16'h1);
    note(3, 16'h0);
    for (k = 0; k < 16; k++) begin
      do_reset(4'(k));
      note(4, {15'h0, k < 3});
      note(5, {15'h0, k < 15});
      note(6, {15'h0, k < 2 || (k > 2 && k < 9) || k == 15});
      if (k < 15) note(7, 16'(k));
    end
    do_reset(4'h0);
    seed = lfsr(seed);
    wr(efpc_pkg::REG_ALERT_MASK, seed[15:0]);
    rd(efpc_pkg::REG_ALERT_MASK, seed[15:0], 16'hffff);
    wr(efpc_pkg::REG_VENDOR_STATUS, 16'hffff);
    rd(efpc_pkg::REG_VENDOR_STATUS, 16'h0000, 16'h0004);
    rd(8'h55, 16'h0000, 16'hffff);
    rd(efpc_pkg::REG_PEAK_CAPTURE, 16'h0000, 16'hffff);
    enable_pin = 1'b1;
    repeat (8) @(negedge clk);
    for (k = 0; k < 6; k++) begin
      {vout_band, vin_high} = 3'(k);
      repeat (3) @(negedge clk);
      note(8, {8'h0, LIM[k]});
    end
    note(2, 16'h0);
    window(0, 1'b0, 150, 240);
    note(1, 16'h1);
    do_reset(4'h0);
    {enable_pin, current_limiting} = 2'b11;
    window(0, 1'b0, 15, 60);
    do_reset(4'h0);
    go_on();
    seed = lfsr(seed);
    pk = {1'b0, seed[14:0]};
    oc_above = 3'b111;
    current_monitor = pk;
    @(negedge clk);
    current_monitor = pk + 16'h0100;
    @(negedge clk);
    current_monitor = pk + 16'h0080;
    repeat (300) @(negedge clk);
    oc_above = 3'b000;
    note(0, 16'h1);
    enable_pin = 1'b0;
    repeat (10) @(negedge clk);
    enable_pin = 1'b1;
    rd(efpc_pkg::REG_PEAK_CAPTURE, pk + 16'h0100, 16'hffff);
    rd(efpc_pkg::REG_PEAK_CAPTURE, 16'h0000, 16'hffff);
    window(2, 1'b1, 0, 40);
    wr(efpc_pkg::REG_OC_CONFIG, 16'h0001);
    oc_above = 3'b001;
    repeat (200) @(negedge clk);
    {oc_above, oc_below_hyst} = 6'b000001;
    repeat (110) @(negedge clk);
    {oc_above, oc_below_hyst} = 6'b001000;
    window(0, 1'b0, 240, 280);
    note(1, 16'h1);
    note(2, 16'h0);
    oc_above = 3'b000;
    rd(efpc_pkg::REG_VENDOR_STATUS, 16'h0018, 16'h001c);
    repeat (100) @(negedge clk);
    note(3, 16'h0);
    enable_pin = 1'b0;
    repeat (10) @(negedge clk);
    enable_pin = 1'b1;
    window(2, 1'b1, 0, 40);
    wr(efpc_pkg::REG_OC_CONFIG, 16'h1010);
    oc_above = 3'b100;
    window(0, 1'b0, 240, 280);
    oc_above = 3'b000;
    window(3, 1'b1, 10, 80);
    window(2, 1'b1, 0, 60);
    host_disable = 1'b1;
    window(2, 1'b0, 0, 5);
    host_disable = 1'b0;
    window(2, 1'b1, 0, 60);
    short_detect = 1'b1;
    window(3, 1'b0, 0, 8);
    do_reset(4'h0);
    link_continue = 1'b0;
    for (k = 0; k < 3; k++) begin
      note(0, 16'h1);
      link_fail_evt = 1'b1;
      @(negedge clk);
      link_fail_evt = 1'b0;
      repeat (3) @(negedge clk);
    end
    window(1, 1'b0, 0, 8);
    note(0, 16'h0);
    rd(efpc_pkg::REG_VENDOR_STATUS, 16'h0004, 16'h0004);
    do_reset(4'h0);
    go_on();
    pull_sl = 1'b1;
    window(0, 1'b0, 45, 80);
    note(1, 16'h1);
    do_reset(4'h3);
    {enable_pin, vout_near_vin, vout_above_th, vgs_ok, over_temp} = 5'h1f;
    repeat (20) @(negedge clk);
    note(1, 16'h1);
    temp_in_slave_band = 1'b1;
    window(1, 1'b0, 0, 12);
    note(0, 16'h1);
    do_reset(4'h0);
    pull_sh = 1'b1;
    wr(efpc_pkg::REG_OC_CONFIG, 16'h1000);
    repeat (10) @(negedge clk);
    {enable_pin, vout_near_vin, vout_above_th, vgs_ok} = 4'hf;
    repeat (20) @(negedge clk);
    note(3, 16'h0);
    pull_sh = 1'b0;
    go_on();
    {over_temp, temp_below_warn} = 2'b10;
    window(0, 1'b0, 0, 12);
    over_temp = 1'b0;
    repeat (40) @(negedge clk);
    note(2, 16'h0);
    note(3, 16'h0);
    temp_below_warn = 1'b1;
    window(2, 1'b1, 4, 40);
    repeat (2) @(negedge clk);
    stop_test();
  end
endmodule
`default_nettype wire
